// ### hw/flash_setup_regs.sv
// state and setup registers of a serial flash, with link-side command entry
// assumes: command source on link_clk, array engine on ref_clk
`timescale 1ns/100ps
module flash_setup_regs import flash_regs_pkg::*; (
	// core clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	// link side command entry
	input  wire logic              link_clk,
	input  wire logic              cmd_valid,
	input  wire cmd_kind_t         cmd_kind,
	input  wire logic [ADDR_W-1:0] cmd_addr,
	input  wire logic [7:0]        cmd_state_data,
	input  wire logic [7:0]        cmd_setup_data,
	input  wire logic              cmd_setup_present,
	output logic                   cmd_ready,
	// link side read back
	output logic [7:0]             state_read,
	output logic [7:0]             setup_read,
	// array engine
	output logic                   array_op_start,
	output cmd_kind_t              array_op_kind,
	output logic [ADDR_W-1:0]      array_op_addr,
	input  wire logic              array_op_done,
	// applied configuration
	output logic                   busy_flag,
	output logic                   write_latch_flag,
	output logic [LEVEL_W-1:0]     protect_level,
	output logic                   protect_origin_sel,
	output logic                   preamble_enable,
	output logic [DRV_W-1:0]       driver_strength,
	output logic [7:0]             drive_ohms_now
);
	// ----------------------------------------------------------------
	// link domain: command capture
	// ----------------------------------------------------------------
	logic              cmd_req;
	logic              cmd_ack_l;
	cmd_kind_t         hold_kind;
	logic [ADDR_W-1:0] hold_addr;
	logic [7:0]        hold_state;
	logic [7:0]        hold_setup;
	logic              hold_setup_ok;
	wire  logic        cmd_take = cmd_valid && cmd_ready;

	assign cmd_ready = (cmd_req == cmd_ack_l);

	// fields stay frozen until the core acknowledges them
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_req       <= 1'b0;
			hold_kind     <= CMD_WRITE_DISABLE;
			hold_addr     <= '0;
			hold_state    <= 8'h00;
			hold_setup    <= 8'h00;
			hold_setup_ok <= 1'b0;
		end else if (cmd_take) begin
			cmd_req       <= !cmd_req;
			hold_kind     <= cmd_kind;
			hold_addr     <= cmd_addr;
			hold_state    <= cmd_state_data;
			hold_setup    <= cmd_setup_data;
			hold_setup_ok <= cmd_setup_present;
		end
	end

	// ----------------------------------------------------------------
	// link domain: snapshot of the registers for reads
	// ----------------------------------------------------------------
	logic       snap_req_l;
	logic       snap_seen_l;
	logic       snap_req_c;
	logic [7:0] snap_state;
	logic [7:0] snap_setup;
	wire  logic snap_new_l = (snap_req_l != snap_seen_l);

	// reads lag the core by a few link cycles; polling hides it
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			snap_seen_l <= 1'b0;
			state_read  <= 8'h00;
			setup_read  <= {SETUP_RSVD, PREAMBLE_RESET, ORIGIN_RESET, DRV_RESET};
		end else if (snap_new_l) begin
			snap_seen_l <= snap_req_l;
			state_read  <= snap_state;
			setup_read  <= snap_setup;
		end
	end

	// ----------------------------------------------------------------
	// crossings
	// ----------------------------------------------------------------
	logic cmd_req_c;
	logic cmd_seen;
	logic snap_ack_c;

	bit_sync u_cmd_req (.clk(ref_clk), .rst_n(rst_n), .d(cmd_req), .q(cmd_req_c));
	bit_sync u_cmd_ack (.clk(link_clk), .rst_n(rst_n), .d(cmd_seen), .q(cmd_ack_l));
	bit_sync u_snap_req (.clk(link_clk), .rst_n(rst_n), .d(snap_req_c), .q(snap_req_l));
	bit_sync u_snap_ack (.clk(ref_clk), .rst_n(rst_n), .d(snap_seen_l), .q(snap_ack_c));

	// ----------------------------------------------------------------
	// core domain: command decode
	// ----------------------------------------------------------------
	core_state_t core_state;
	logic        wr_done;
	wire logic   cmd_new  = (cmd_req_c != cmd_seen);
	wire logic   exec_ok  = cmd_new && (core_state == CORE_IDLE);
	wire logic   kind_pe  = (hold_kind == CMD_PAGE_PROGRAM) ||
		(hold_kind == CMD_SECTOR_ERASE) || (hold_kind == CMD_BLOCK_ERASE);
	wire logic   hit      = protect_hit(hold_addr, protect_level, protect_origin_sel);
	wire logic   go_wren  = exec_ok && (hold_kind == CMD_WRITE_ENABLE);
	wire logic   go_wrdi  = exec_ok && (hold_kind == CMD_WRITE_DISABLE);
	wire logic   go_state = exec_ok && (hold_kind == CMD_WRITE_STATE)
		&& write_latch_flag;
	wire logic   go_pe    = exec_ok && kind_pe && write_latch_flag && !hit;
	wire logic   go_chip  = exec_ok && (hold_kind == CMD_CHIP_ERASE) && write_latch_flag
		&& (protect_level == LEVEL_NONE);
	wire logic   go_array = go_pe || go_chip;
	wire logic   op_done  = ((core_state == CORE_ARRAY) && array_op_done) ||
		((core_state == CORE_STATE_WR) && wr_done);

	// every request is acknowledged; refused ones simply leave no trace
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			cmd_seen <= 1'b0;
		else
			cmd_seen <= cmd_req_c;
	end

	// ----------------------------------------------------------------
	// core domain: operation sequencing
	// ----------------------------------------------------------------
	core_state_t next_core_state;

	// busy spans from acceptance to the completion pulse
	always_comb begin
		next_core_state = core_state;
		case (core_state)
			CORE_IDLE: begin
				if (go_array)
					next_core_state = CORE_ARRAY;
				else if (go_state)
					next_core_state = CORE_STATE_WR;
			end
			CORE_ARRAY: begin
				if (array_op_done)
					next_core_state = CORE_IDLE;
			end
			CORE_STATE_WR: begin
				if (wr_done)
					next_core_state = CORE_IDLE;
			end
			default: next_core_state = CORE_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			core_state <= CORE_IDLE;
		else
			core_state <= next_core_state;
	end

	assign busy_flag = (core_state != CORE_IDLE);

	op_timer u_wr_timer (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.start   (go_state),
		.done    (wr_done)
	);

	// array request, one pulse with kind and address held after
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			array_op_start <= 1'b0;
			array_op_kind  <= CMD_PAGE_PROGRAM;
			array_op_addr  <= '0;
		end else begin
			array_op_start <= go_array;
			if (go_array) begin
				array_op_kind <= hold_kind;
				array_op_addr <= hold_addr;
			end
		end
	end

	// ----------------------------------------------------------------
	// core domain: registers
	// ----------------------------------------------------------------
	// write latch: completion clears it, which is why the host polls
	// busy first and the latch second
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			write_latch_flag <= 1'b0;
		else if (go_wren)
			write_latch_flag <= 1'b1;
		else if (go_wrdi || op_done)
			write_latch_flag <= 1'b0;
	end

	// only the state write touches these; reserved bits are dropped
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			protect_level      <= LEVEL_RESET;
			protect_origin_sel <= ORIGIN_RESET;
			preamble_enable    <= PREAMBLE_RESET;
			driver_strength    <= DRV_RESET;
		end else if (go_state) begin
			protect_level <= hold_state[STATE_LEVEL_LSB +: LEVEL_W];
			if (hold_setup_ok) begin
				protect_origin_sel <= protect_origin_sel
					| hold_setup[SETUP_ORIGIN_BIT];
				preamble_enable    <= hold_setup[SETUP_PREAMBLE_BIT];
				driver_strength    <= hold_setup[SETUP_DRV_LSB +: DRV_W];
			end
		end
	end

	// impedance readout for the pad calibration; reset value folded at elaboration
	localparam logic [7:0] DRV_RESET_OHMS = drive_ohms(DRV_RESET);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			drive_ohms_now <= DRV_RESET_OHMS;
		else
			drive_ohms_now <= drive_ohms(driver_strength);
	end

	// ----------------------------------------------------------------
	// core domain: snapshot publisher
	// ----------------------------------------------------------------
	logic snap_pend;

	// reserved positions are hard zero in both bytes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			snap_pend  <= 1'b0;
			snap_req_c <= 1'b0;
			snap_state <= 8'h00;
			snap_setup <= 8'h00;
		end else if (!snap_pend) begin
			snap_pend  <= 1'b1;
			snap_req_c <= !snap_req_c;
			snap_state <= {STATE_RSVD, protect_level, write_latch_flag, busy_flag};
			snap_setup <= {SETUP_RSVD, preamble_enable, protect_origin_sel,
				driver_strength};
		end else if (snap_ack_c == snap_req_c) begin
			snap_pend <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_BUSY_ON_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(go_state || go_array) |=> busy_flag)
		else $error("busy not raised after accepted write");

	AST_BUSY_HOLDS: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(core_state == CORE_STATE_WR) && !wr_done |=> busy_flag)
		else $error("busy dropped before the state write ended");

	AST_NO_LATCH_NO_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		exec_ok && !write_latch_flag |=> !array_op_start && !busy_flag)
		else $error("write accepted with latch clear");

	AST_SHIELD: assert property (@(posedge ref_clk) disable iff (!rst_n)
		array_op_start && (array_op_kind != CMD_CHIP_ERASE) |->
		!protect_hit(array_op_addr, protect_level, protect_origin_sel))
		else $error("program or erase started inside shield");

	AST_CHIP_LEVEL: assert property (@(posedge ref_clk) disable iff (!rst_n)
		array_op_start && (array_op_kind == CMD_CHIP_ERASE) |->
		(protect_level == LEVEL_NONE))
		else $error("chip erase started with shield set");

	AST_FIELDS_BY_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!$stable(protect_level) || !$stable(preamble_enable) ||
		!$stable(driver_strength) || !$stable(protect_origin_sel) |-> $past(go_state))
		else $error("field changed without state write");

	AST_ORIGIN_ONCE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		protect_origin_sel |=> protect_origin_sel)
		else $error("origin bit returned to top");

	AST_DRV_APPLIED: assert property (@(posedge ref_clk) disable iff (!rst_n)
		go_state && hold_setup_ok |=> ##1
		drive_ohms_now == drive_ohms($past(hold_setup[SETUP_DRV_LSB +: DRV_W], 2)))
		else $error("driver strength not applied after write");

	AST_LATCH_CLEARS: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$fell(busy_flag) |-> !write_latch_flag)
		else $error("latch still set after write completed");

	AST_RSVD_ZERO: assert property (@(posedge link_clk) disable iff (!rst_n)
		(state_read[7:6] == STATE_RSVD) && (setup_read[7:5] == SETUP_RSVD))
		else $error("reserved bits read nonzero");
endmodule // flash_setup_regs

// ### hw/flash_regs_pkg.sv
// constants, types and decode helpers for the flash state/setup register block
// assumes: shared by the register core and its helpers, no other dependencies
package flash_regs_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 10000;           // ref_clk at 100 MHz
	localparam int STATE_WR_TIME_NS = 40000;        // state write busy time, plain default
	localparam int STATE_WR_CYCLES =
		(STATE_WR_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TIMER_W = 13;

	// ----------------------------------------------------------------
	// array geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 26;
	localparam int BLOCK_LSB = 16;                  // 64 KB blocks
	localparam int BLOCK_W = 10;
	localparam logic [11:0] BLOCK_TOTAL = 12'h400;
	localparam logic [11:0] SPAN_ONE = 12'h001;

	// ----------------------------------------------------------------
	// register fields and reset values
	// ----------------------------------------------------------------
	localparam int LEVEL_W = 4;
	localparam int DRV_W = 3;
	localparam logic [3:0] LEVEL_RESET = 4'h0;
	localparam logic [3:0] LEVEL_NONE = 4'h0;
	localparam logic [3:0] LEVEL_FULL = 4'hB;       // span reaches the whole array
	localparam logic ORIGIN_RESET = 1'b0;           // top of array
	localparam logic PREAMBLE_RESET = 1'b0;
	localparam logic [2:0] DRV_RESET = 3'h5;        // 30 ohm code
	localparam logic [1:0] STATE_RSVD = 2'h0;
	localparam logic [2:0] SETUP_RSVD = 3'h0;
	localparam int SETUP_DRV_LSB = 0;
	localparam int SETUP_ORIGIN_BIT = 3;
	localparam int SETUP_PREAMBLE_BIT = 4;
	localparam int STATE_LEVEL_LSB = 2;

	typedef enum logic [2:0] {
		CMD_WRITE_ENABLE,
		CMD_WRITE_DISABLE,
		CMD_WRITE_STATE,
		CMD_PAGE_PROGRAM,
		CMD_SECTOR_ERASE,
		CMD_BLOCK_ERASE,
		CMD_CHIP_ERASE
	} cmd_kind_t;

	typedef enum logic [1:0] {
		CORE_IDLE,
		CORE_ARRAY,
		CORE_STATE_WR
	} core_state_t;

	// driver code to impedance in ohms
	function automatic logic [7:0] drive_ohms(input logic [2:0] code);
		case (code)
			3'h0: drive_ohms = 8'h92;
			3'h1: drive_ohms = 8'h4C;
			3'h2: drive_ohms = 8'h34;
			3'h3: drive_ohms = 8'h29;
			3'h4: drive_ohms = 8'h22;
			3'h5: drive_ohms = 8'h1E;
			3'h6: drive_ohms = 8'h1A;
			default: drive_ohms = 8'h18;
		endcase
	endfunction

	// protected block count for a level; zero means unprotected
	function automatic logic [11:0] protect_span(input logic [3:0] level);
		if (level == LEVEL_NONE)
			protect_span = 12'h000;
		else if (level >= LEVEL_FULL)
			protect_span = BLOCK_TOTAL;
		else
			protect_span = SPAN_ONE << (level - 4'h1);
	endfunction

	// true when an address falls into the shielded area
	function automatic logic protect_hit(input logic [ADDR_W-1:0] addr,
		input logic [3:0] level, input logic origin);
		logic [11:0] blk;
		logic [11:0] span;
		blk = {2'h0, addr[BLOCK_LSB +: BLOCK_W]};
		span = protect_span(level);
		if (origin)
			protect_hit = blk < span;
		else
			protect_hit = (blk + span) >= BLOCK_TOTAL;
	endfunction

endpackage

// ### hw/bit_sync.sv
// two flip-flop synchroniser for a single level or toggle
// assumes: destination clock and asynchronous active-low reset
`timescale 1ns/100ps
module bit_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// data
	input  wire logic d,
	output logic      q
);
	logic meta;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= 1'b0;
			q    <= 1'b0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule // bit_sync

// ### hw/op_timer.sv
// one-shot busy timer for internal register writes
// assumes: start arrives only while the timer is idle
`timescale 1ns/100ps
module op_timer import flash_regs_pkg::*; #(
	parameter int CYCLES = STATE_WR_CYCLES
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	// control
	input  wire logic start,
	output logic      done
);
	logic [TIMER_W-1:0] count;
	logic               run;
	wire  logic         last = run && (count == TIMER_W'(1));

	// count down from the load value, pulse done the cycle after the count reaches one
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			run   <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= last;
			if (start) begin
				count <= TIMER_W'(CYCLES);
				run   <= 1'b1;
			end else if (run) begin
				count <= count - TIMER_W'(1);
				run   <= !last;
			end
		end
	end
endmodule // op_timer

// ### testbench/array_engine_model.sv
// array engine stand-in: answers every operation start with one done pulse
// assumes: ref_clk domain, at most one operation outstanding at a time
`timescale 1ns/100ps
module array_engine_model (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// operation handshake
	input  wire logic       array_op_start,
	input  wire logic [7:0] op_latency,
	output logic            array_op_done
);
	// ----------------------------------------------------------------
	// latency counter
	// ----------------------------------------------------------------
	logic [7:0] remain;
	logic       running;

	// latency is sampled at start, so the bench may change it between ops
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			remain <= 8'h00;
			running <= 1'b0;
			array_op_done <= 1'b0;
		end else begin
			array_op_done <= running && (remain == 8'h00);
			if (array_op_start) begin
				running <= 1'b1;
				remain <= op_latency;
			end else if (running && remain == 8'h00)
				running <= 1'b0;
			else if (running)
				remain <= remain - 8'h01;
		end
	end
endmodule // array_engine_model

// ### testbench/flash_status_config_regs_tb_top.sv
// self-checking bench for the flash state and setup register block
// assumes: design files and the engine model are compiled before this one
`timescale 1ns/100ps
module flash_status_config_regs_tb_top import flash_regs_pkg::*;;
	logic              ref_clk, link_clk, rst_n, cmd_valid, cmd_setup_present, cmd_ready;
	cmd_kind_t         cmd_kind, array_op_kind;
	logic [ADDR_W-1:0] cmd_addr, array_op_addr;
	logic [7:0]        cmd_state_data, cmd_setup_data, state_read, setup_read, op_lat;
	logic              array_op_start, array_op_done, busy_flag, write_latch_flag;
	logic [3:0]        protect_level;
	logic              protect_origin_sel, preamble_enable;
	logic [2:0]        driver_strength;
	logic [7:0]        drive_ohms_now;
	int                n_mismatch, checks_done;
	localparam logic [7:0] OHMS [8] = '{8'h92, 8'h4C, 8'h34, 8'h29, 8'h22, 8'h1E, 8'h1A, 8'h18};

	flash_setup_regs uut (.ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk),
		.cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
		.cmd_state_data(cmd_state_data), .cmd_setup_data(cmd_setup_data),
		.cmd_setup_present(cmd_setup_present), .cmd_ready(cmd_ready),
		.state_read(state_read), .setup_read(setup_read), .array_op_start(array_op_start),
		.array_op_kind(array_op_kind), .array_op_addr(array_op_addr),
		.array_op_done(array_op_done), .busy_flag(busy_flag),
		.write_latch_flag(write_latch_flag), .protect_level(protect_level),
		.protect_origin_sel(protect_origin_sel), .preamble_enable(preamble_enable),
		.driver_strength(driver_strength), .drive_ohms_now(drive_ohms_now));
	array_engine_model engine (.ref_clk(ref_clk), .rst_n(rst_n),
		.array_op_start(array_op_start), .op_latency(op_lat), .array_op_done(array_op_done));

	// two unrelated clocks, link offset so edges never line up
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		link_clk = 1'b0;
		#3;
		forever #7.5 link_clk = ~link_clk;
	end

	// ----------------------------------------------------------------
	// bus and compare tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one command pulse; sampling on the falling link edge avoids races with ready
	task automatic send(input cmd_kind_t k, input logic [ADDR_W-1:0] a, input logic [7:0] sd,
		input logic [7:0] cd, input logic cp);
		int n;
		n = 0;
		@(negedge link_clk);
		while (cmd_ready !== 1'b1 && n < 300) begin
			@(negedge link_clk);
			n++;
		end
		@(posedge link_clk);
		cmd_valid <= 1'b1;
		cmd_kind <= k;
		cmd_addr <= a;
		cmd_state_data <= sd;
		cmd_setup_data <= cd;
		cmd_setup_present <= cp;
		@(posedge link_clk);
		cmd_valid <= 1'b0;
		n = 0;
		while (cmd_ready !== 1'b0 && n < 4) begin
			@(negedge link_clk);
			n++;
		end
		n = 0;
		while (cmd_ready !== 1'b1 && n < 300) begin
			@(negedge link_clk);
			n++;
		end
		chk("cmd_ready", 8'h01, {7'h0, cmd_ready});
		repeat (3) @(negedge ref_clk);
	endtask

	// host waits for busy to clear, only then looks at the latch
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy_flag !== 1'b0 && n < 5000) begin
			@(negedge ref_clk);
			n++;
		end
		chk("busy_flag", 8'h00, {7'h0, busy_flag});
		chk("write_latch_flag", 8'h00, {7'h0, write_latch_flag});
	endtask

	// enable, state write, then compare both read-back bytes after the snapshot
	task automatic write_state_regs_cmd(input logic [7:0] sd, input logic [7:0] cd, input logic cp,
		input logic [7:0] exp_setup);
		send(CMD_WRITE_ENABLE, '0, 8'h00, 8'h00, 1'b0);
		chk("write_latch_flag", 8'h01, {7'h0, write_latch_flag});
		send(CMD_WRITE_STATE, '0, sd, cd, cp);
		chk("busy_flag", 8'h01, {7'h0, busy_flag});
		chk("protect_level", {4'h0, sd[5:2]}, {4'h0, protect_level});
		wait_idle();
		repeat (20) @(negedge link_clk);
		chk("state_read", {2'h0, sd[5:2], 2'h0}, state_read);
		chk("setup_read", exp_setup, setup_read);
	endtask

	// array op: refused ones leave busy low and the latch standing
	task automatic arr_op(input cmd_kind_t k, input logic [ADDR_W-1:0] a, input logic take);
		send(CMD_WRITE_ENABLE, '0, 8'h00, 8'h00, 1'b0);
		send(k, a, 8'h00, 8'h00, 1'b0);
		chk("busy_flag", {7'h0, take}, {7'h0, busy_flag});
		if (take) begin
			chk("array_op_kind", {5'h0, k}, {5'h0, array_op_kind});
			chk("array_op_addr", a[25:18], array_op_addr[25:18]);
			wait_idle();
		end else
			chk("write_latch_flag", 8'h01, {7'h0, write_latch_flag});
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		repeat (20) @(negedge link_clk);
		chk("state_read", 8'h00, state_read);
		chk("setup_read", 8'h05, setup_read);
		chk("drive_ohms_now", 8'h1E, drive_ohms_now);
	endtask

	task automatic t_gate();
		send(CMD_WRITE_STATE, '0, 8'h3C, 8'h1F, 1'b1);
		chk("busy_flag", 8'h00, {7'h0, busy_flag});
		send(CMD_PAGE_PROGRAM, '0, 8'h00, 8'h00, 1'b0);
		chk("busy_flag", 8'h00, {7'h0, busy_flag});
		send(CMD_WRITE_ENABLE, '0, 8'h00, 8'h00, 1'b0);
		send(CMD_WRITE_DISABLE, '0, 8'h00, 8'h00, 1'b0);
		chk("write_latch_flag", 8'h00, {7'h0, write_latch_flag});
		repeat (20) @(negedge link_clk);
		chk("state_read", 8'h00, state_read);
	endtask

	task automatic t_fields();
		write_state_regs_cmd(8'hC7, 8'hF1, 1'b1, 8'h11);
		chk("drive_ohms_now", 8'h4C, drive_ohms_now);
		for (int c = 0; c < 8; c++) begin
			write_state_regs_cmd(8'h04, {5'h0, 3'(c)}, 1'b1, {5'h0, 3'(c)});
			chk("driver_strength", {5'h0, 3'(c)}, {5'h0, driver_strength});
			chk("drive_ohms_now", OHMS[c], drive_ohms_now);
		end
		chk("preamble_enable", 8'h00, {7'h0, preamble_enable});
	endtask

	// level 1 from the top shields only the last block
	task automatic t_protect();
		arr_op(CMD_PAGE_PROGRAM, 26'h3FF0000, 1'b0);
		arr_op(CMD_SECTOR_ERASE, 26'h3FF1000, 1'b0);
		op_lat <= 8'hC8;
		arr_op(CMD_BLOCK_ERASE, 26'h0000000, 1'b1);
		arr_op(CMD_CHIP_ERASE, 26'h0000000, 1'b0);
		write_state_regs_cmd(8'h00, 8'h00, 1'b0, 8'h07);
		op_lat <= 8'h28;
		arr_op(CMD_CHIP_ERASE, 26'h0000000, 1'b1);
		arr_op(CMD_PAGE_PROGRAM, 26'h3FF0000, 1'b1);
	endtask

	// bottom origin moves the shield to block zero and cannot be undone
	task automatic t_origin();
		write_state_regs_cmd(8'h04, 8'h08, 1'b1, 8'h08);
		chk("protect_origin_sel", 8'h01, {7'h0, protect_origin_sel});
		chk("drive_ohms_now", 8'h92, drive_ohms_now);
		arr_op(CMD_SECTOR_ERASE, 26'h0000000, 1'b0);
		arr_op(CMD_PAGE_PROGRAM, 26'h3FF0000, 1'b1);
		write_state_regs_cmd(8'h04, 8'h00, 1'b1, 8'h08);
		chk("protect_origin_sel", 8'h01, {7'h0, protect_origin_sel});
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// main sequence
	initial begin
		n_mismatch = 0;
		checks_done = 0;
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_kind = CMD_WRITE_ENABLE;
		cmd_addr = '0;
		cmd_state_data = 8'h00;
		cmd_setup_data = 8'h00;
		cmd_setup_present = 1'b0;
		op_lat = 8'h28;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset();
		t_gate();
		t_fields();
		t_protect();
		t_origin();
		summarize();
	end

	// 12 accepted state writes of 4001 busy cycles each; limit leaves ample room
	initial begin
		#900000;
		n_mismatch++;
		$display("Error watchdog expected finish seen hang");
		summarize();
	end
endmodule // flash_status_config_regs_tb_top
